/* File: fepc_external_data_move_route.sv */
`timescale 1ns/1ps
`default_nettype none
module fepc_external_data_move_route
    import fepc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pwe,
    input wire logic external_data_move_wr,
    input wire logic [15:0] external_data_move_addr,
    input wire logic [7:0] external_data_move_data,
    output logic xram_wr,
    output fepc_flash_wr_s flash_wr,
    output logic byte_done
);

    // ==========================================
    // Store steering: data RAM unless program write is enabled
    assign xram_wr = external_data_move_wr & ~pwe;
    assign byte_done = external_data_move_wr & pwe;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flash_wr <= '0;
        end else begin
            flash_wr.wr <= external_data_move_wr & pwe;
            if (external_data_move_wr & pwe) begin
                flash_wr.addr <= external_data_move_addr;
                flash_wr.data <= external_data_move_data;
            end
        end
    end

endmodule
`default_nettype wire

/* File: fepc_flash_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Writing 0x55 to erase command starts page erase of a page written since the last 0x55.
// - Writing 0xAA starts mass erase if enable armed and debug port enabled.
// - Other erase command values are ignored; register reads as zero.
// - Page register holds page 0..127 to erase; resets to zero.
// - Program write enable redirects data-pointer stores from data RAM into flash.
// - Program write enable clears itself after each flash byte written.
// - Program write enable writes blocked while interrupts globally enabled.
// - Mass erase enable is write-only, resets disabled, arms one mass erase.
// - Security bit clears on reset, can only be set afterwards.
// - Security bit blocks external reads of flash and engine program RAM.
// - Control bit 7 is read-only, one while preboot runs.
module fepc_flash_ctrl
    import fepc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fepc_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic int_global_en,
    input wire logic debug_port_en,
    input wire logic preboot_active,
    input wire logic external_data_move_wr,
    input wire logic [15:0] external_data_move_addr,
    input wire logic [7:0] external_data_move_data,
    output logic xram_wr,
    output fepc_flash_wr_s flash_wr,
    output fepc_erase_s erase_req,
    input wire logic flash_busy,
    output logic erase_active,
    output logic ext_read_block
);

    // ==========================================
    // Decode
    function automatic logic hit(input fepc_sfr_req_s r, input logic [7:0] a);
        hit = r.addr == a;
    endfunction

    // Key match on a write to the erase command address
    function automatic logic key_hit(input logic we, input logic [7:0] d, input logic [7:0] k);
        key_hit = we && d == k;
    endfunction

    // ==========================================
    // Registers and decoded strobes
    logic wr_erase;
    logic wr_ctrl;
    logic wr_page;
    logic pwe_r;
    logic meen_r;
    logic secure_r;
    logic [6:0] page_r;
    logic page_valid_r;
    logic byte_done;
    logic preboot_s1_r;
    logic preboot_r;
    logic debug_s1_r;
    logic debug_r;
    fepc_state_e state_r;
    logic page_key;
    logic mass_key;

    assign wr_erase = sfr_req.wr & hit(sfr_req, FEPC_ADDR_ERASE_CMD);
    assign wr_ctrl = sfr_req.wr & hit(sfr_req, FEPC_ADDR_CONTROL);
    assign wr_page = sfr_req.wr & hit(sfr_req, FEPC_ADDR_PAGE);
    // Hit covers reads and writes alike, so the core can steer its read mux
    assign sfr_hit = hit(sfr_req, FEPC_ADDR_ERASE_CMD) | hit(sfr_req, FEPC_ADDR_CONTROL)
        | hit(sfr_req, FEPC_ADDR_PAGE);

    // A key only counts when it lands on the erase command address
    assign page_key = key_hit(wr_erase, sfr_req.wdata, FEPC_KEY_PAGE_ERASE);
    assign mass_key = key_hit(wr_erase, sfr_req.wdata, FEPC_KEY_MASS_ERASE);

    // ==========================================
    // Pin synchronisers
    // Both pins are asynchronous; only the second stage is ever read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            preboot_s1_r <= 1'b0;
            preboot_r <= 1'b0;
            debug_s1_r <= 1'b0;
            debug_r <= 1'b0;
        end else begin
            preboot_s1_r <= preboot_active;
            preboot_r <= preboot_s1_r;
            debug_s1_r <= debug_port_en;
            debug_r <= debug_s1_r;
        end
    end

    // ==========================================
    // Program write enable
    // A store steered to flash wins over a control write in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwe_r <= 1'b0;
        end else if (byte_done) begin
            pwe_r <= 1'b0;
        end else if (wr_ctrl && !int_global_en) begin
            pwe_r <= sfr_req.wdata[FEPC_BIT_PWE];
        end
    end

    // ==========================================
    // Security latch: set-only until reset
    // Zero writes fall through, so only a chip reset can lift the read block
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            secure_r <= 1'b0;
        end else if (wr_ctrl && sfr_req.wdata[FEPC_BIT_SECURE]) begin
            secure_r <= 1'b1;
        end
    end

    // External readers of flash and engine program RAM are gated on this
    assign ext_read_block = secure_r;

    // ==========================================
    // Page address and one-shot qualifiers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            page_r <= FEPC_PAGE_RST[6:0];
            page_valid_r <= 1'b0;
        end else if (wr_page) begin
            page_r <= sfr_req.wdata[6:0];
            page_valid_r <= 1'b1;
        end else if (page_key) begin
            // Spent even when the erase is refused, so a stale page never fires later
            page_valid_r <= 1'b0;
        end
    end

    // Consumed by any mass-erase attempt so a stale arm never carries over
    // A zero write disarms as well
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meen_r <= 1'b0;
        end else if (wr_ctrl) begin
            meen_r <= sfr_req.wdata[FEPC_BIT_MEEN];
        end else if (mass_key) begin
            meen_r <= 1'b0;
        end
    end

    // ==========================================
    // Erase sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= FEPC_IDLE;
            erase_req <= '0;
        end else begin
            erase_req.page_erase <= 1'b0;
            erase_req.mass_erase <= 1'b0;
            case (state_r)
                FEPC_IDLE: begin
                    // Keys that arrive while an erase runs are dropped here
                    if (page_key && page_valid_r) begin
                        erase_req.page_erase <= 1'b1;
                        erase_req.page <= page_r;
                        state_r <= FEPC_PAGE_BUSY;
                    end else if (mass_key && meen_r && debug_r) begin
                        erase_req.mass_erase <= 1'b1;
                        state_r <= FEPC_MASS_BUSY;
                    end
                    // Any other value falls through with no effect
                end
                FEPC_PAGE_BUSY, FEPC_MASS_BUSY: begin
                    // Wait one cycle for the array to raise busy, then for it to drop
                    // The strobe cycle itself never ends the erase
                    if (!flash_busy && !erase_req.page_erase && !erase_req.mass_erase) begin
                        state_r <= FEPC_IDLE;
                    end
                end
                default: state_r <= FEPC_IDLE;
            endcase
        end
    end

    // Busy covers the strobe cycle and the whole array busy time
    assign erase_active = state_r != FEPC_IDLE;

    // ==========================================
    // Read mux; erase command is write-only and reads zero
    always_comb begin
        sfr_rdata = 8'h00;
        if (sfr_req.rd) begin
            if (hit(sfr_req, FEPC_ADDR_ERASE_CMD)) begin
                sfr_rdata = FEPC_ERASE_CMD_RST;
            end else if (hit(sfr_req, FEPC_ADDR_CONTROL)) begin
                // Mass-erase enable is write-only and reads back as zero
                sfr_rdata[FEPC_BIT_PWE] = pwe_r;
                sfr_rdata[FEPC_BIT_SECURE] = secure_r;
                sfr_rdata[FEPC_BIT_PREBOOT] = preboot_r;
            end else if (hit(sfr_req, FEPC_ADDR_PAGE)) begin
                // Top bit of the page register always reads zero
                sfr_rdata = {1'b0, page_r};
            end
        end
    end

    // ==========================================
    // Store steering and the one-shot flash byte write
    fepc_external_data_move_route u_route (
        .sys_clk(sys_clk),
        .rst(rst),
        .pwe(pwe_r),
        .external_data_move_wr(external_data_move_wr),
        .external_data_move_addr(external_data_move_addr),
        .external_data_move_data(external_data_move_data),
        .xram_wr(xram_wr),
        .flash_wr(flash_wr),
        .byte_done(byte_done)
    );

endmodule
`default_nettype wire

/* File: fepc_flash_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module fepc_flash_ctrl_monitor
    import fepc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fepc_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic preboot_active,
    input wire logic external_data_move_wr,
    input wire logic xram_wr,
    input wire fepc_flash_wr_s flash_wr,
    input wire fepc_erase_s erase_req,
    input wire logic ext_read_block
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic kw, cw, pk, mk;
    assign kw = sfr_req.wr && sfr_req.addr == FEPC_ADDR_ERASE_CMD;
    assign cw = sfr_req.wr && sfr_req.addr == FEPC_ADDR_CONTROL;
    assign pk = kw && sfr_req.wdata == FEPC_KEY_PAGE_ERASE;
    assign mk = kw && sfr_req.wdata == FEPC_KEY_MASS_ERASE;
    property p_page;
        erase_req.page_erase |-> $past(pk);
    endproperty
    a_page: assert property (p_page) else $error("page strobe without key");
    property p_mass;
        erase_req.mass_erase |-> $past(mk);
    endproperty
    a_mass: assert property (p_mass) else $error("mass strobe without key");
    property p_ign;
        kw && !pk && !mk |=> !erase_req.page_erase && !erase_req.mass_erase;
    endproperty
    a_ign: assert property (p_ign) else $error("erase from bad pattern");
    property p_fall;
        !$fell(ext_read_block);
    endproperty
    a_fall: assert property (p_fall) else $error("security cleared");
    property p_sset;
        cw && sfr_req.wdata[FEPC_BIT_SECURE] |=> ext_read_block;
    endproperty
    a_sset: assert property (p_sset) else $error("read block not set");
    property p_route;
        external_data_move_wr |=> flash_wr.wr != $past(xram_wr);
    endproperty
    a_route: assert property (p_route) else $error("store routed twice or lost");
    property p_one;
        external_data_move_wr && $past(external_data_move_wr) && !$past(cw) |-> xram_wr;
    endproperty
    a_one: assert property (p_one) else $error("write enable not spent");
    property p_pre;
        sfr_req.rd && sfr_req.addr == FEPC_ADDR_CONTROL && !preboot_active
            && !$past(preboot_active) && !$past(preboot_active, 2)
            |-> !sfr_rdata[FEPC_BIT_PREBOOT];
    endproperty
    a_pre: assert property (p_pre) else $error("preboot flag stuck");
endmodule
bind fepc_flash_ctrl fepc_flash_ctrl_monitor u_mon (
    .sys_clk, .rst, .sfr_req, .sfr_rdata, .preboot_active, .external_data_move_wr, .xram_wr,
    .flash_wr, .erase_req, .ext_read_block
);
`default_nettype wire

/* File: fepc_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Flash array: busy for a chosen time after each erase strobe
module fepc_flash_model
    import fepc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fepc_erase_s erase_req,
    input wire logic [3:0] busy_len,
    output logic flash_busy
);
    logic [3:0] cnt_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            cnt_r <= 4'h0;
        else if (erase_req.page_erase || erase_req.mass_erase)
            cnt_r <= busy_len;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end
    assign flash_busy = cnt_r != 4'h0;
endmodule
`default_nettype wire

/* File: fepc_pkg.sv */
`default_nettype none
package fepc_pkg;

    // ==========================================
    // Register addresses on the SFR bus
    localparam logic [7:0] FEPC_ADDR_ERASE_CMD = 8'h94;
    localparam logic [7:0] FEPC_ADDR_CONTROL = 8'hB2;
    localparam logic [7:0] FEPC_ADDR_PAGE = 8'hB7;

    // ==========================================
    // Key patterns and reset values
    localparam logic [7:0] FEPC_KEY_PAGE_ERASE = 8'h55;
    localparam logic [7:0] FEPC_KEY_MASS_ERASE = 8'hAA;
    localparam logic [7:0] FEPC_ERASE_CMD_RST = 8'h00;
    localparam logic [7:0] FEPC_PAGE_RST = 8'h00;
    localparam logic [7:0] FEPC_PAGE_MAX = 8'h7F;

    // ==========================================
    // Control register field positions
    localparam int FEPC_BIT_PWE = 0;
    localparam int FEPC_BIT_MEEN = 1;
    localparam int FEPC_BIT_SECURE = 6;
    localparam int FEPC_BIT_PREBOOT = 7;

    // ==========================================
    // Bundles
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fepc_sfr_req_s;

    typedef struct packed {
        logic page_erase;
        logic mass_erase;
        logic [6:0] page;
    } fepc_erase_s;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } fepc_flash_wr_s;

    typedef enum logic [1:0] {
        FEPC_IDLE,
        FEPC_PAGE_BUSY,
        FEPC_MASS_BUSY
    } fepc_state_e;

endpackage
`default_nettype wire

/* File: flash_erase_program_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module flash_erase_program_control_bench;
    import fepc_pkg::*;
    localparam logic [7:0] ctl = FEPC_ADDR_CONTROL, ers = FEPC_ADDR_ERASE_CMD;
    localparam logic [7:0] pga = FEPC_ADDR_PAGE;
    logic sys_clk = 0, rst = 1, int_global_en = 0, debug_port_en = 0, preboot_active = 1;
    logic external_data_move_wr = 0, flash_busy, xram_wr, erase_active, ext_read_block, sfr_hit;
    logic [15:0] external_data_move_addr = '0;
    logic [7:0] external_data_move_data = '0, sfr_rdata, seed = 8'h5B, pg;
    logic [3:0] busy_len = '0;
    fepc_sfr_req_s sfr_req = '0;
    fepc_flash_wr_s flash_wr;
    fepc_erase_s erase_req;
    logic [25:0] exp_q[$];
    int n_mismatch = 0, num_checks = 0;
    fepc_flash_ctrl dut (.sys_clk, .rst, .sfr_req, .sfr_rdata, .sfr_hit, .int_global_en,
        .debug_port_en, .preboot_active, .external_data_move_wr, .external_data_move_addr, .external_data_move_data, .xram_wr,
        .flash_wr, .erase_req, .flash_busy, .erase_active, .ext_read_block);
    fepc_flash_model u_flash (.sys_clk, .rst, .erase_req, .busy_len, .flash_busy);
    function automatic logic [7:0] lf(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic acc(input logic w, input logic [7:0] a, d, e);
        @(negedge sys_clk);
        sfr_req = {w, !w, a, d};
        #1;
        `CHK(sfr_hit, (a == ctl) | (a == ers) | (a == pga))
        if (!w) `CHK(sfr_rdata, e)
        @(negedge sys_clk);
        sfr_req = '0;
    endtask
    task automatic mv(input logic [15:0] a, input logic [7:0] d, input logic [1:0] k);
        @(negedge sys_clk);
        {external_data_move_wr, external_data_move_addr, external_data_move_data} = {1'b1, a, d};
        exp_q.push_back({k, a, d});
    endtask
    task automatic wait_idle;
        repeat (24) if (erase_active) @(negedge sys_clk);
        `CHK(erase_active, 1'b0)
    endtask
    task automatic got(input logic [25:0] v);
        logic [25:0] e;
        e = exp_q.size() ? exp_q.pop_front() : 26'bx;
        `CHK(v, e)
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========
    // Every store or erase strobe must match the oldest expected event
    always @(posedge sys_clk) begin
        // A flash byte reports a cycle after its store, so it is older than a store seen now
        if (!rst && flash_wr.wr !== 1'b0) got({2'h3, flash_wr.addr, flash_wr.data});
        if (!rst && xram_wr !== 1'b0) got({2'h0, external_data_move_addr, external_data_move_data});
        if (!rst && erase_req.page_erase !== 1'b0) got({2'h1, 17'h0, erase_req.page});
        if (!rst && erase_req.mass_erase !== 1'b0) got({2'h2, 24'h0});
    end
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        n_mismatch++;
        $display("ERROR %0t: timeout", $time);
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk) rst = 0;
        repeat (3) @(negedge sys_clk);
        acc(0, ctl, 0, 8'h80);
        acc(0, pga, 0, 8'h00);
        acc(0, ers, 0, 8'h00);
        preboot_active = 0;
        repeat (3) @(negedge sys_clk);
        acc(0, ctl, 0, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            seed = lf(seed);
            pg = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : {1'b0, seed[6:0]};
            busy_len = seed[3:0];
            acc(1, pga, pg, 0);
            acc(0, pga, 0, pg);
            acc(1, ers ^ 8'h01, 8'h55, 0);
            exp_q.push_back({2'h1, 16'h0, pg});
            acc(1, ers, 8'h55, 0);
            wait_idle;
            acc(1, ers, 8'h55, 0);
            acc(1, ers, {6'h16, i[1:0]}, 0);
        end
        $display("page erase test done");
        debug_port_en = 1;
        repeat (3) @(negedge sys_clk);
        acc(1, ctl, 8'h02, 0);
        acc(0, ctl, 0, 8'h00);
        exp_q.push_back({2'h2, 24'h0});
        acc(1, ers, 8'hAA, 0);
        wait_idle;
        acc(1, ers, 8'hAA, 0);
        debug_port_en = 0;
        repeat (3) @(negedge sys_clk);
        acc(1, ctl, 8'h02, 0);
        acc(1, ers, 8'hAA, 0);
        $display("mass erase test done");
        acc(1, ctl, 8'h01, 0);
        acc(0, ctl, 0, 8'h01);
        mv({seed, 8'h10}, seed, 2'h3);
        mv({seed, 8'h11}, ~seed, 2'h0);
        @(negedge sys_clk) external_data_move_wr = 0;
        int_global_en = 1;
        acc(1, ctl, 8'h01, 0);
        mv(16'h0200, seed, 2'h0);
        @(negedge sys_clk) external_data_move_wr = 0;
        $display("program write test done");
        acc(1, ctl, 8'h40, 0);
        acc(1, ctl, 8'h00, 0);
        acc(0, ctl, 0, 8'h40);
        `CHK(ext_read_block, 1'b1)
        rst = 1;
        repeat (2) @(negedge sys_clk);
        rst = 0;
        repeat (3) @(negedge sys_clk);
        acc(0, ctl, 0, 8'h00);
        `CHK(ext_read_block, 1'b0)
        `CHK(exp_q.size(), 0)
        $display("security test done");
        print_verdict;
    end
endmodule
`default_nettype wire
